/* File: rtl/vpd_dispatch.sv */
// Packet dispatcher: splits fetch packets into execute packets and
// issues them to eight units; tracks result timing; APB registers.
// Assumes the fetch side holds fp_data while fp_valid and not fp_ready.
//
// Behaviour
// RULE1 - Take eight-word aligned fetch packets whole
// RULE2 - Chain bit zero joins next instruction (code joins on chain bit one, zero ends the packet)
// RULE3 - Scan chain bits lowest address first
// RULE4 - Execute packet holds one to eight
// RULE5 - Each packet instruction uses distinct unit
// RULE6 - Last slot always ends execute packet
// RULE7 - Single-cycle result readable next cycle
// RULE8 - Multiply result readable two cycles later
// RULE9 - Load writes four cycles later, separate port
// RULE10 - Branch takes effect five cycles later
// RULE11 - Every unit accepts one per cycle
// RULE12 - Issue cycle is first execute phase
// RULE13 - Route classes to proper unit types
// RULE14 - Restricted classes only on side two
// RULE15 - Saturating add/subtract clamp on overflow
// RULE16 - Extract shifts left then right
// RULE17 - Field clear/set between begin, end
// RULE18 - Arithmetic and logical right shifts
// RULE19 - Long operands are forty bits
// RULE20 - Three-bit condition field plus zero bit
// RULE21 - Cross bit takes operand opposite side
// RULE22 - Zero bit chooses zero/nonzero test
// RULE23 - Branch entry discards lower slots
// RULE24 - Stall fetch until last packet issues
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module vpd_dispatch
	import vpd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fp_valid,
	input wire logic [vpd_pkg::PKT_W-1:0] fp_data,
	input wire logic [2:0] fp_start,
	output logic fp_ready,
	input wire logic [vpd_pkg::NUM_CREGS-1:0] cond_zero,
	input wire logic [vpd_pkg::LONG_W-1:0] lane_src1,
	input wire logic [vpd_pkg::LONG_W-1:0] lane_src2,
	output logic [vpd_pkg::NUM_UNITS-1:0] unit_valid,
	output logic [vpd_pkg::PKT_W-1:0] unit_instr,
	output logic [vpd_pkg::NUM_UNITS-1:0] unit_exec,
	output logic [vpd_pkg::NUM_UNITS-1:0] unit_src2_side,
	output logic [vpd_pkg::NUM_UNITS-1:0] result_rdy,
	output logic [1:0] load_wb,
	output logic branch_taken,
	output logic [vpd_pkg::LONG_W-1:0] lane_result,
	output logic lane_result_valid
);
	import vpd_pkg::*;

	localparam logic [2:0] LAST_SLOT = 3'(NUM_SLOTS - 1);
	localparam int unsigned UNIT_L1 = 0;
	localparam int unsigned UNIT_S1 = 1;
	localparam int unsigned UNIT_M1 = 2;
	localparam int unsigned UNIT_S2 = 5;

	typedef enum logic {ST_EMPTY, ST_ISSUE} vpd_state_t;

	vpd_state_t state_q;
	logic [PKT_W-1:0] pkt_q;
	logic [2:0] ptr_q, ptr_d;
	logic [31:0] ctrl_q, epcount_q;
	logic conflict_q, illegal_q;
	logic [NUM_SLOTS-1:0] ep_mask;
	logic [2:0] ep_end;
	logic last_ep, advance, take, conflict, illegal;
	logic [NUM_UNITS-1:0] issue_d, exec;
	logic [PKT_W-1:0] instr_d;
	logic [2:0] s_unit [NUM_SLOTS];
	logic [2:0] s_dly [NUM_SLOTS];
	logic [NUM_SLOTS-1:0] s_br, s_ld, s_legal;
	logic [2:0] dly_d [NUM_UNITS];
	logic [2:0] dly_q [NUM_UNITS];
	logic [NUM_UNITS-1:0] br_d, br_q, ld_d, ld_q;
	logic [PEND_W-1:0] pend_q [NUM_UNITS];
	logic [BR_PIPE_W-1:0] brpipe_q;
	logic [LD_PIPE_W-1:0] ldpipe_q [2];
	logic apb_wr, addr_ok, clr_flags;

	////////////////////////////////////////////////////////////////////
	// Per-slot decoders
	for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
		vpd_slot_decode u_dec (
			.instr(pkt_q[g*INSTR_W +: INSTR_W]),
			.unit_idx(s_unit[g]),
			.delay(s_dly[g]),
			.is_branch(s_br[g]),
			.is_load(s_ld[g]),
			.legal(s_legal[g])
		);
	end

	////////////////////////////////////////////////////////////////////
	// APB slave, zero wait states
	assign pready = 1'b1;
	assign apb_wr = psel && penable && pwrite;
	assign addr_ok = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
		(paddr == REG_EPCOUNT);
	assign pslverr = psel && penable && !addr_ok;
	assign clr_flags = apb_wr && (paddr == REG_CTRL) && pwdata[CTRL_CLR_POS];

	// Control register, clear bit self-clears
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= CTRL_RST;
		end else if (apb_wr && paddr == REG_CTRL) begin
			ctrl_q <= {31'h0, pwdata[CTRL_EN_POS]};
		end
	end

	// Read data mux
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				REG_CTRL: prdata <= ctrl_q;
				REG_STATUS: prdata <= {25'h0, ptr_q, 1'b0, illegal_q,
					conflict_q, state_q == ST_ISSUE};
				REG_EPCOUNT: prdata <= epcount_q;
				default: prdata <= 32'h0;
			endcase
		end
	end

	// Sticky faults: a new fault wins over the clear
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			conflict_q <= 1'b0;
			illegal_q <= 1'b0;
		end else begin
			conflict_q <= (advance && conflict) || (conflict_q && !clr_flags);
			illegal_q <= (advance && illegal) || (illegal_q && !clr_flags);
		end
	end

	////////////////////////////////////////////////////////////////////
	// RULE3 scan from lowest slot
	always_comb begin
		logic stop;
		stop = 1'b0;
		ep_mask = '0;
		ep_end = ptr_q;
		for (int k = 0; k < NUM_SLOTS; k++) begin
			if (3'(k) >= ptr_q && !stop) begin
				ep_mask[k] = 1'b1;
				ep_end = 3'(k);
				// RULE2 chain bit
				// RULE6 last slot closes packet
				if (!pkt_q[k*INSTR_W + PBIT_POS] || 3'(k) == LAST_SLOT) begin
					stop = 1'b1;
				end
			end
		end
	end

	// RULE5 unit claim per execute packet
	always_comb begin
		issue_d = '0;
		instr_d = '0;
		br_d = '0;
		ld_d = '0;
		conflict = 1'b0;
		illegal = 1'b0;
		for (int u = 0; u < NUM_UNITS; u++) begin
			dly_d[u] = DLY_SINGLE;
		end
		for (int k = 0; k < NUM_SLOTS; k++) begin
			if (ep_mask[k] && !s_legal[k]) begin
				illegal = 1'b1;
			end else if (ep_mask[k] && issue_d[s_unit[k]]) begin
				conflict = 1'b1; // later claimant dropped
			end else if (ep_mask[k]) begin
				issue_d[s_unit[k]] = 1'b1;
				instr_d[s_unit[k]*INSTR_W +: INSTR_W] =
					pkt_q[k*INSTR_W +: INSTR_W];
				dly_d[s_unit[k]] = s_dly[k];
				br_d[s_unit[k]] = s_br[k];
				ld_d[s_unit[k]] = s_ld[k];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Packet sequencing
	assign last_ep = (ep_end == LAST_SLOT);
	assign advance = (state_q == ST_ISSUE) && ctrl_q[CTRL_EN_POS];
	// RULE24 stall fetch until last packet
	assign fp_ready = ctrl_q[CTRL_EN_POS] &&
		((state_q == ST_EMPTY) || last_ep);
	assign take = fp_valid && fp_ready;

	// RULE23 entry slot skips lower slots
	always_comb begin
		ptr_d = ptr_q;
		if (take) begin
			ptr_d = fp_start;
		end else if (advance) begin
			ptr_d = ep_end + 3'h1;
		end
	end

	// RULE1 whole packet capture
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_EMPTY;
			pkt_q <= '0;
			ptr_q <= 3'h0;
		end else begin
			ptr_q <= ptr_d;
			if (take) begin
				state_q <= ST_ISSUE;
				pkt_q <= fp_data;
			end else if (advance && last_ep) begin
				state_q <= ST_EMPTY;
			end
		end
	end

	// Execute packet counter
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			epcount_q <= 32'h0;
		end else if (advance) begin
			epcount_q <= epcount_q + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// RULE12 issue registers mark the first execute phase
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			unit_valid <= '0;
			unit_instr <= '0;
			br_q <= '0;
			ld_q <= '0;
			for (int u = 0; u < NUM_UNITS; u++) begin
				dly_q[u] <= DLY_SINGLE;
			end
		end else begin
			unit_valid <= advance ? issue_d : '0;
			unit_instr <= instr_d;
			br_q <= br_d;
			ld_q <= ld_d;
			dly_q <= dly_d;
		end
	end

	// Condition test and cross path, evaluated in the issue cycle
	for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
		logic [2:0] creg;
		logic zbit, cz;
		assign creg = unit_instr[u*INSTR_W + CREG_LSB +: 3];
		assign zbit = unit_instr[u*INSTR_W + Z_POS];
		assign cz = cond_zero[3'(creg - CREG_FIRST)];
		// RULE20 condition register select
		// RULE22 zero or nonzero test
		assign exec[u] = (creg == CREG_UNCOND) ? 1'b1 : (zbit ? cz : !cz);
		assign unit_exec[u] = unit_valid[u] && exec[u];
		// RULE21 second operand opposite side
		assign unit_src2_side[u] = (u >= NUM_UNITS / 2) ^
			unit_instr[u*INSTR_W + CROSS_POS];
		assign result_rdy[u] = pend_q[u][0];
	end

	////////////////////////////////////////////////////////////////////
	// RULE7 single-cycle timing
	// RULE8 multiply timing
	// RULE11 new entry every cycle
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int u = 0; u < NUM_UNITS; u++) begin
				pend_q[u] <= '0;
			end
		end else begin
			for (int u = 0; u < NUM_UNITS; u++) begin
				pend_q[u] <= (pend_q[u] >> 1) | (unit_exec[u] ?
					PEND_W'(1) << dly_q[u] : PEND_W'(0));
			end
		end
	end

	// RULE10 branch effect pipe
	// RULE9 load write pipe, own port per side
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			brpipe_q <= '0;
			ldpipe_q[0] <= '0;
			ldpipe_q[1] <= '0;
		end else begin
			brpipe_q <= {|(unit_exec & br_q), brpipe_q[BR_PIPE_W-1:1]};
			ldpipe_q[0] <= {|(unit_exec[3:0] & ld_q[3:0]),
				ldpipe_q[0][LD_PIPE_W-1:1]};
			ldpipe_q[1] <= {|(unit_exec[7:4] & ld_q[7:4]),
				ldpipe_q[1][LD_PIPE_W-1:1]};
		end
	end

	assign branch_taken = brpipe_q[0];
	assign load_wb = {ldpipe_q[1][0], ldpipe_q[0][0]};

	////////////////////////////////////////////////////////////////////
	// Side-one execute lane: shift unit first, else logic unit
	logic [31:0] li, a32, b32, fmask, ext_l, r32;
	logic [32:0] s33;
	logic [4:0] csta, cstb;
	logic lane_sel, lane_ovf;
	vpd_class_t lcls;

	assign lane_sel = unit_exec[UNIT_S1] || unit_exec[UNIT_L1];
	assign li = unit_exec[UNIT_S1] ? unit_instr[UNIT_S1*INSTR_W +: INSTR_W]
		: unit_instr[UNIT_L1*INSTR_W +: INSTR_W];
	assign lcls = vpd_class_t'(li[CLASS_LSB +: CLASS_W]);
	assign a32 = lane_src1[31:0];
	assign b32 = lane_src2[31:0];
	assign csta = li[CSTA_LSB +: 5];
	assign cstb = li[CSTB_LSB +: 5];
	assign ext_l = a32 << csta;

	// RULE17 field mask from begin to end
	for (genvar j = 0; j < 32; j++) begin : g_mask
		assign fmask[j] = (5'(j) >= csta) && (5'(j) <= cstb);
	end

	// RULE15 overflow detect on 33-bit sum
	always_comb begin
		s33 = (lcls == CL_SSUB) ? {a32[31], a32} - {b32[31], b32}
			: {a32[31], a32} + {b32[31], b32};
		lane_ovf = s33[32] != s33[31];
	end

	// Lane operation select
	always_comb begin
		r32 = 32'h0;
		unique case (lcls)
			CL_ADD: r32 = a32 + b32;
			CL_SUB: r32 = a32 - b32;
			CL_AND: r32 = a32 & b32;
			CL_CMP: r32 = {31'h0, a32 == b32};
			CL_SHL: r32 = a32 << b32[4:0];
			// RULE15 clamp on overflow
			CL_SADD, CL_SSUB: r32 = !lane_ovf ? s33[31:0] :
				(s33[32] ? 32'h8000_0000 : 32'h7fff_ffff);
			// RULE18 arithmetic and logical shifts
			CL_SHR: r32 = 32'($signed(a32) >>> b32[4:0]);
			CL_SHRU: r32 = a32 >> b32[4:0];
			// RULE16 left then right
			CL_EXT: r32 = 32'($signed(ext_l) >>> cstb);
			CL_EXTU: r32 = ext_l >> cstb;
			CL_CLR: r32 = a32 & ~fmask;
			CL_SET: r32 = a32 | fmask;
			default: r32 = 32'h0;
		endcase
	end

	// RULE7 lane result in next cycle
	// RULE19 forty-bit long add
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lane_result <= '0;
			lane_result_valid <= 1'b0;
		end else begin
			lane_result_valid <= lane_sel;
			lane_result <= (lcls == CL_ADD40) ? lane_src1 + lane_src2
				: {8'h00, r32};
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	sequence s_mid_packet;
		advance && !last_ep;
	endsequence

	sequence s_last_packet;
		advance && last_ep;
	endsequence

	a_fetch_stall: assert property (s_mid_packet |-> !fp_ready) // RULE24
		else $error("fetch not stalled mid packet");
	a_packet_restart: assert property (s_last_packet |-> fp_ready) // RULE24
		else $error("fetch not released at last packet");
	a_chain_step: assert property (s_mid_packet |=>
		ptr_q == $past(ep_end) + 3'h1) // RULE2
		else $error("chain pointer wrong");
	a_entry_slot: assert property (take |=>
		ptr_q == $past(fp_start) && state_q == ST_ISSUE) // RULE23
		else $error("entry slot not honoured");
	a_packet_size: assert property (advance |->
		ep_mask != '0 && ep_mask[ptr_q]) // RULE4
		else $error("empty execute packet");
	a_unit_unique: assert property (advance && !conflict && !illegal |->
		$countones(ep_mask) == $countones(issue_d)) // RULE5
		else $error("instruction lost without conflict");
	a_branch_delay: assert property ((|(unit_exec & br_q)) |->
		##5 branch_taken) // RULE10
		else $error("branch not taken at fifth cycle");
	a_load_write: assert property (unit_exec[3] && ld_q[3] |->
		##4 load_wb[0]) // RULE9
		else $error("load write late or missing");
	a_mpy_result: assert property (unit_exec[UNIT_M1] &&
		dly_q[UNIT_M1] == DLY_MPY |-> ##2 result_rdy[UNIT_M1]) // RULE8
		else $error("multiply result not ready");
	a_single_result: assert property (unit_exec[UNIT_L1] &&
		dly_q[UNIT_L1] == DLY_SINGLE |-> ##1 result_rdy[UNIT_L1]) // RULE7
		else $error("single-cycle result not ready");
	a_side_two: assert property (unit_valid[UNIT_S1] |->
		vpd_class_t'(unit_instr[UNIT_S1*INSTR_W + CLASS_LSB +: CLASS_W])
		!= CL_CRMOVE) // RULE14
		else $error("control move on side one");

endmodule

/* File: rtl/vpd_pkg.sv */
// Constants, field layout and types shared by the packet dispatcher.
// Assumes a single 200 MHz core clock and 32-bit instruction words.
package vpd_pkg;

	localparam int unsigned NUM_SLOTS = 8;
	localparam int unsigned INSTR_W = 32;
	localparam int unsigned PKT_W = 256;
	localparam int unsigned NUM_UNITS = 8;
	localparam int unsigned LONG_W = 40;
	localparam int unsigned NUM_CREGS = 5;
	localparam int unsigned CLK_PERIOD_NS = 5;

	// Instruction field positions
	localparam int unsigned PBIT_POS = 0;
	localparam int unsigned SIDE_POS = 1;
	localparam int unsigned HINT_LSB = 5;
	localparam int unsigned CLASS_LSB = 7;
	localparam int unsigned CLASS_W = 5;
	localparam int unsigned CROSS_POS = 12;
	localparam int unsigned CSTB_LSB = 13;
	localparam int unsigned CSTA_LSB = 18;
	localparam int unsigned Z_POS = 28;
	localparam int unsigned CREG_LSB = 29;

	// Condition register field codes
	localparam logic [2:0] CREG_UNCOND = 3'h0;
	localparam logic [2:0] CREG_FIRST = 3'h2;
	localparam logic [2:0] CREG_LAST = 3'h6;

	// Delay slots per instruction type
	localparam logic [2:0] DLY_SINGLE = 3'h0;
	localparam logic [2:0] DLY_MPY = 3'h1;
	localparam logic [2:0] DLY_LOAD = 3'h4;
	localparam logic [2:0] DLY_BRANCH = 3'h5;

	// Pipeline lengths for delayed events
	localparam int unsigned PEND_W = 7;
	localparam int unsigned BR_PIPE_W = 5;
	localparam int unsigned LD_PIPE_W = 4;

	// Register offsets and reset values
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_EPCOUNT = 8'h08;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam int unsigned CTRL_EN_POS = 0;
	localparam int unsigned CTRL_CLR_POS = 1;
	localparam int unsigned ST_BUSY_POS = 0;
	localparam int unsigned ST_CONFL_POS = 1;
	localparam int unsigned ST_ILL_POS = 2;
	localparam int unsigned ST_PTR_LSB = 4;

	// Unit index = {side, unit type}
	typedef enum logic [1:0] {UT_LOGIC, UT_SHIFT, UT_MULT, UT_DADDR} vpd_utype_t;

	typedef enum logic [4:0] {
		CL_NOP, CL_ADD, CL_SUB, CL_AND, CL_MPY, CL_LOAD, CL_STORE, CL_ADDR,
		CL_LOAD15, CL_STORE15, CL_BR_DISP, CL_BR_REG, CL_BR_RP, CL_CRMOVE,
		CL_MVK, CL_SHL, CL_SHR, CL_SHRU, CL_EXT, CL_EXTU, CL_CLR, CL_SET,
		CL_CMP, CL_NORM, CL_SAT, CL_SADD, CL_SSUB, CL_ADD40
	} vpd_class_t;

	localparam logic [4:0] CLASS_MAX = 5'h1b;

endpackage

/* File: rtl/vpd_slot_decode.sv */
// Per-slot decoder: class to functional unit, delay slots, legality.
// Assumes the instruction word is stable while the dispatcher looks at it.
`timescale 1ns/1ps
module vpd_slot_decode
	import vpd_pkg::*;
(
	input wire logic [31:0] instr,
	output logic [2:0] unit_idx,
	output logic [2:0] delay,
	output logic is_branch,
	output logic is_load,
	output logic legal
);

	vpd_class_t cls;
	vpd_utype_t utype;
	logic side;
	logic [1:0] hint;
	logic [2:0] creg;
	logic z;

	assign cls = vpd_class_t'(instr[CLASS_LSB +: CLASS_W]);
	assign hint = instr[HINT_LSB +: 2];
	assign creg = instr[CREG_LSB +: 3];
	assign z = instr[Z_POS];

	////////////////////////////////////////////////////////////////////
	// RULE13 class routing
	always_comb begin
		utype = UT_LOGIC;
		side = instr[SIDE_POS];
		delay = DLY_SINGLE;
		is_branch = 1'b0;
		is_load = 1'b0;
		unique case (cls)
			CL_ADD, CL_SUB: utype = (hint == 2'h2) ? UT_DADDR :
				(hint == 2'h1) ? UT_SHIFT : UT_LOGIC;
			CL_AND: utype = (hint == 2'h1) ? UT_SHIFT : UT_LOGIC;
			CL_MPY: begin
				utype = UT_MULT;
				delay = DLY_MPY; // RULE8 one slot
			end
			CL_LOAD: begin
				utype = UT_DADDR;
				delay = DLY_LOAD;
				is_load = 1'b1;
			end
			CL_STORE, CL_ADDR: utype = UT_DADDR;
			// RULE14 long offset side two
			CL_LOAD15: begin
				utype = UT_DADDR;
				side = 1'b1;
				delay = DLY_LOAD;
				is_load = 1'b1;
			end
			CL_STORE15: begin
				utype = UT_DADDR;
				side = 1'b1;
			end
			CL_BR_DISP: begin
				utype = UT_SHIFT;
				delay = DLY_BRANCH;
				is_branch = 1'b1;
			end
			// RULE14 register branch side two
			CL_BR_REG, CL_BR_RP: begin
				utype = UT_SHIFT;
				side = 1'b1;
				delay = DLY_BRANCH;
				is_branch = 1'b1;
			end
			CL_CRMOVE: begin
				utype = UT_SHIFT;
				side = 1'b1;
			end
			CL_MVK, CL_SHL, CL_SHR, CL_SHRU, CL_EXT, CL_EXTU, CL_CLR,
				CL_SET: utype = UT_SHIFT;
			CL_CMP, CL_NORM, CL_SAT, CL_SADD, CL_SSUB,
				CL_ADD40: utype = UT_LOGIC;
			default: utype = UT_LOGIC; // NOP and illegal codes
		endcase
	end

	assign unit_idx = {side, utype};

	// RULE20 reserved condition codes
	assign legal = (instr[CLASS_LSB +: CLASS_W] <= CLASS_MAX) &&
		(cls != CL_NOP) &&
		((creg == CREG_UNCOND && !z) ||
		(creg >= CREG_FIRST && creg <= CREG_LAST));

endmodule

/* File: test/vpd_dispatch_test.sv */
// Self-checking bench for the dispatcher: random packets and APB access.
// Assumes vpd_pkg, the design and the fetch model are compiled first.
`timescale 1ns/1ps
module vpd_dispatch_test;
	import vpd_pkg::*;
	logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, unit_valid, unit_exec, unit_src2_side, result_rdy;
	logic [31:0] pwdata, prdata, seed, rnd, rd;
	logic fp_valid, fp_ready, branch_taken, lane_result_valid, en, err;
	logic [PKT_W-1:0] fp_data, unit_instr, d;
	logic [2:0] fp_start;
	logic [NUM_CREGS-1:0] cond_zero;
	logic [LONG_W-1:0] lane_src1, lane_src2, lane_result;
	logic [1:0] load_wb;
	logic [7:0] exp_q[$];
	logic [PKT_W-1:0] exp_w[$];
	logic [7:0] h[0:4];
	int fail_count = 0;
	int compares = 0;
	int eps = 0;

	vpd_dispatch dut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fp_valid(fp_valid), .fp_data(fp_data), .fp_start(fp_start),
		.fp_ready(fp_ready), .cond_zero(cond_zero), .lane_src1(lane_src1),
		.lane_src2(lane_src2), .unit_valid(unit_valid),
		.unit_instr(unit_instr), .unit_exec(unit_exec),
		.unit_src2_side(unit_src2_side), .result_rdy(result_rdy),
		.load_wb(load_wb), .branch_taken(branch_taken),
		.lane_result(lane_result), .lane_result_valid(lane_result_valid));
	vpd_fetch_model fetch (.sys_clk(sys_clk), .arst_n(arst_n),
		.fp_ready(fp_ready), .fp_valid(fp_valid), .fp_data(fp_data),
		.fp_start(fp_start));

	////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic chk(input logic [PKT_W-1:0] s, e, input string m);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch at %0t: %s seen %h exp %h", $time, m, s, e);
		end
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Word for unit u: c holds creg, zero bit and cross bit
	function automatic logic [31:0] mk(int u, logic p, logic [4:0] c);
		logic [4:0] cl;
		case (u % 4)
			0: cl = p ? CL_SADD : CL_CMP;
			1: cl = (u > 3) ? CL_BR_DISP : CL_SHL;
			2: cl = CL_MPY;
			default: cl = (u > 3) ? CL_LOAD15 : CL_LOAD;
		endcase
		return {c[4:1], 15'h0, c[0] && u % 4 != 3, cl, 5'h0, u[2], p};
	endfunction
	task automatic apb(logic w, logic [7:0] a, logic [31:0] wd);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		chk(n < 50, 1, "pready");
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Model split of a taken packet into execute packets
	task automatic push_eps();
		logic [7:0] m;
		logic [PKT_W-1:0] w;
		logic [31:0] iw;
		int u;
		m = '0;
		w = '0;
		for (int k = fp_start; k < 8; k++) begin
			iw = fp_data[32*k +: 32];
			u = (iw[11:7] == CL_CMP || iw[11:7] == CL_SADD) ? 0 :
				(iw[11:7] == CL_MPY) ? 2 : 3;
			u = (iw[11:7] == CL_SHL || iw[11:7] == CL_BR_DISP) ? 1 : u;
			u = u + 4 * iw[1];
			if (!m[u])
				w[32*u +: 32] = iw;
			m[u] = 1'b1;
			if (!iw[0] || k == 7) begin
				exp_q.push_back(m);
				exp_w.push_back(w);
				m = '0;
				w = '0;
			end
		end
	endtask
	task automatic send_rand(int i);
		logic [7:0] pb;
		logic [2:0] cr;
		seed = lfsr(seed);
		pb = (i % 3 == 0) ? 8'hff : seed[7:0];
		for (int k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			cr = (seed % 6 == 0) ? 3'h0 : 3'(seed % 6 + 1);
			d[32*k +: 32] = mk((k + i) % 8, pb[k], {cr, cr != 0 && seed[8],
				seed[9]});
		end
		fetch.send(d, (i % 4 == 1) ? seed[12:10] : 3'h0);
	endtask
	task automatic wait_idle();
		int n = 0;
		while ((fetch.q_data.size() != 0 || fp_valid || exp_q.size() != 0)
			&& n < 3000) begin
			@(negedge sys_clk);
			n++;
		end
		repeat (8) @(negedge sys_clk);
		chk(n < 3000, 1, "drain");
	endtask
	task automatic summarize();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Clock, random operands and condition registers
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		rnd = lfsr(rnd);
		cond_zero <= rnd[4:0];
		lane_src1 <= {rnd[7:0], rnd};
		lane_src2 <= {rnd[15:8], rnd[15:0], rnd[31:16]};
	end

	// Monitor compares every cycle against the model
	always @(negedge sys_clk) begin : mon
		logic [7:0] m, ue, ss;
		logic [PKT_W-1:0] w, km;
		logic [31:0] iw, a, b;
		logic [LONG_W-1:0] lx;
		longint sv;
		if (!arst_n) begin
			for (int i = 0; i < 5; i++)
				h[i] = '0;
		end else begin
			if (h[0][0] | h[0][1])
				chk(lane_result, lx, "lane data");
			m = '0;
			w = '0;
			km = '0;
			ue = '0;
			ss = '0;
			if (unit_valid != 8'h00 && exp_q.size() != 0) begin
				m = exp_q.pop_front();
				w = exp_w.pop_front();
			end
			eps += (unit_valid != 8'h00);
			chk(unit_valid, m, "issue");
			for (int u = 0; u < 8; u++) begin
				iw = w[32*u +: 32];
				km[32*u +: 32] = {32{m[u]}};
				ue[u] = m[u] && (iw[31:29] == CREG_UNCOND ||
					cond_zero[iw[31:29] - 3'h2] == iw[28]);
				ss[u] = m[u] && (u[2] ^ iw[12]);
			end
			chk(unit_instr & km, w, "words");
			chk(unit_exec & m, ue, "exec");
			chk(unit_src2_side & m, ss, "side");
			chk(result_rdy & 8'hdf, (h[0] & 8'h13) | (h[1] & 8'h44) |
				(h[4] & 8'h88), "result");
			chk(load_wb, {h[3][7], h[3][3]}, "load");
			chk(branch_taken, h[4][5], "branch");
			chk(lane_result_valid, h[0][0] | h[0][1], "lane");
			// Lane model: S1 shift first, else L1 compare or add
			a = lane_src1[31:0];
			b = lane_src2[31:0];
			sv = $signed(a) + $signed(b);
			if (ue[1])
				lx = {8'h00, a << b[4:0]};
			else if (w[11:7] == CL_CMP)
				lx = {39'h0, a == b};
			else if (sv > 64'sh7fff_ffff)
				lx = 40'h00_7fff_ffff;
			else if (sv < -64'sh8000_0000)
				lx = 40'h00_8000_0000;
			else
				lx = {8'h00, sv[31:0]};
			chk(fp_ready, en && exp_q.size() <= 1, "ready");
			if (fp_valid && fp_ready)
				push_eps();
			for (int i = 4; i > 0; i--)
				h[i] = h[i-1];
			h[0] = ue;
		end
	end

	// Watchdog
	initial begin
		#(20000 * CLK_PERIOD_NS);
		fail_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		summarize();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{cond_zero, lane_src1, lane_src2} = '0;
		en = 1'b1;
		seed = 32'h3753;
		rnd = 32'h3753;
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rd, CTRL_RST, "ctrl reset");
		apb(1'b0, 8'h40, 32'h0);
		chk({err, rd}, 33'h1_0000_0000, "unmapped");
		$display("test registers done");
		for (int r = 0; r < 2; r++) begin
			fetch.slow = 3 * r;
			for (int i = 20 * r; i < 20 * r + 20; i++)
				send_rand(i);
			wait_idle();
		end
		$display("test random packets done");
		for (int k = 0; k < 8; k++)
			d[32*k +: 32] = mk((k == 1) ? 0 : k, 1'b1, 5'h0);
		fetch.send(d, 3'h0);
		wait_idle();
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd[ST_CONFL_POS], 1'b1, "conflict flag");
		apb(1'b0, REG_EPCOUNT, 32'h0);
		chk(rd, eps, "ep count");
		apb(1'b1, REG_CTRL, 32'h3);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd[ST_CONFL_POS], 1'b0, "flag clear");
		$display("test conflict done");
		apb(1'b1, REG_CTRL, 32'h0);
		en = 1'b0;
		send_rand(41);
		repeat (10) @(posedge sys_clk);
		apb(1'b1, REG_CTRL, 32'h1);
		en = 1'b1;
		wait_idle();
		$display("test disable done");
		summarize();
	end
endmodule

/* File: test/vpd_fetch_model.sv */
// Fetch side model: offers queued 256-bit fetch packets to the dispatcher.
// Assumes the bench fills the queue through send and sets slow for gaps.
`timescale 1ns/1ps
module vpd_fetch_model
	import vpd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic fp_ready,
	output logic fp_valid,
	output logic [vpd_pkg::PKT_W-1:0] fp_data,
	output logic [2:0] fp_start
);
	import vpd_pkg::*;
	logic [PKT_W-1:0] q_data[$];
	logic [2:0] q_start[$];
	int slow = 0;
	int wait_n = 0;

	////////////////////////////////////////////////////////////////////////
	// Queue one packet with its entry slot
	task automatic send(input logic [PKT_W-1:0] d, input logic [2:0] s);
		q_data.push_back(d);
		q_start.push_back(s);
	endtask

	// Offer, hold until taken, then release with a changing pattern
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fp_valid <= 1'b0;
			fp_data <= '0;
			fp_start <= 3'h0;
			wait_n = 0;
		end else if (fp_valid && !fp_ready) begin
			fp_valid <= 1'b1;
		end else if (q_data.size() != 0 && wait_n == 0) begin
			fp_valid <= 1'b1;
			fp_data <= q_data.pop_front();
			fp_start <= q_start.pop_front();
			wait_n = slow;
		end else begin
			fp_valid <= 1'b0;
			fp_data <= ~fp_data;
			fp_start <= ~fp_start;
			if (wait_n > 0)
				wait_n--;
		end
	end
endmodule
